// ===== core/frbg_rate_gen.sv
// frbg_rate_gen: per-channel rate generator with divisor registers.
// assumes: register writes arrive as single-cycle strobes on clk_sys;
// the host port decodes combinationally but its registers and read data are clocked by clk_sys, the oscillator clock.
// Notes on behaviour
// - reset restores all registers and outputs
// - each channel owns prescaler and generator
// - handshake bit seven picks divide 1/4
// - divisor one to 65535.9375 in sixteenths
// - reset divisor is exactly one
// - low/high bytes integer, fraction separate
// - low nibble adds sixteenths zero to 15
// - bits 5:4 pick 16X, 8X, 4X
// - sampling tick drives transmit and receive
// - prescaler quarters the resulting data rate
// - 8X odd fraction gives 1/16 jitter
// - 4X odd fraction gives 1/8 jitter
// - host port runs on the oscillator clock
// - bit lasts 16, 8 or 4 ticks
module frbg_rate_gen #(
  parameter int NUM_CH = 2,
  parameter int INT_W  = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              reg_wr,
  input  wire logic [1:0]        reg_sel,
  input  wire logic [0:0]        reg_ch,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  output logic      [NUM_CH-1:0] samp_tick,
  output logic      [NUM_CH-1:0] bit_tick,
  output logic      [NUM_CH-1:0] bit_mid
);
  logic [7:0] div_low_r  [NUM_CH];
  logic [7:0] div_high_r [NUM_CH];
  logic [7:0] div_frac_r [NUM_CH];
  logic [7:0] hs_ctrl_r  [NUM_CH];
  logic [7:0] rdata_r, rdata_nxt;

  // ticks per bit for a sampling code
  function automatic logic [4:0] ticks_per_bit(input logic [1:0] code);
    unique case (code)
      frbg_pkg::SAMP_8X: ticks_per_bit = frbg_pkg::TICKS_8X;
      frbg_pkg::SAMP_4X: ticks_per_bit = frbg_pkg::TICKS_4X;
      default:           ticks_per_bit = frbg_pkg::TICKS_16X;
    endcase
  endfunction

  // port needs no divider
  // register read path; the host may read any register in any cycle
  always_comb begin
    unique case (reg_sel)
      frbg_pkg::SEL_DIV_LOW:  rdata_nxt = div_low_r[reg_ch];
      frbg_pkg::SEL_DIV_HIGH: rdata_nxt = div_high_r[reg_ch];
      frbg_pkg::SEL_DIV_FRAC: rdata_nxt = div_frac_r[reg_ch];
      default:                rdata_nxt = hs_ctrl_r[reg_ch];
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata = rdata_r;

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      logic [7:0] low_nxt, high_nxt, frac_nxt, hs_nxt;
      logic       tick;
      logic [4:0] bcnt_r, bcnt_nxt;
      logic       btick_r, btick_nxt, bmid_r, bmid_nxt, stick_r;
      logic [4:0] tpb;
      logic       sel_me;

      assign sel_me = reg_wr && (reg_ch == 1'(c));

      always_comb begin
        low_nxt  = div_low_r[c];
        high_nxt = div_high_r[c];
        frac_nxt = div_frac_r[c];
        hs_nxt   = hs_ctrl_r[c];
        if (sel_me) begin
          unique case (reg_sel)
            frbg_pkg::SEL_DIV_LOW:  low_nxt  = reg_wdata;
            frbg_pkg::SEL_DIV_HIGH: high_nxt = reg_wdata;
            frbg_pkg::SEL_DIV_FRAC: frac_nxt = reg_wdata;
            default:                hs_nxt   = reg_wdata;
          endcase
        end
      end

      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          div_low_r[c]  <= frbg_pkg::DIV_LOW_RESET;
          div_high_r[c] <= frbg_pkg::DIV_HIGH_RESET;
          div_frac_r[c] <= frbg_pkg::DIV_FRAC_RESET;
          hs_ctrl_r[c]  <= 8'h00;
        end else begin
          div_low_r[c]  <= low_nxt;
          div_high_r[c] <= high_nxt;
          div_frac_r[c] <= frac_nxt;
          hs_ctrl_r[c]  <= hs_nxt;
        end
      end

      frbg_chan_div #(
        .INT_W (INT_W)
      ) u_div (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .prescale_en (hs_ctrl_r[c][frbg_pkg::PRESCALE_BIT]),
        .div_int     (INT_W'({div_high_r[c], div_low_r[c]})),
        .div_frac    (div_frac_r[c][frbg_pkg::FRAC_LSB +: frbg_pkg::FRAC_W]),
        .samp_tick   (tick)
      );

      assign tpb = ticks_per_bit(div_frac_r[c][frbg_pkg::SAMP_LSB +: 2]);

      always_comb begin
        bcnt_nxt  = bcnt_r;
        btick_nxt = 1'b0;
        bmid_nxt  = 1'b0;
        if (tick) begin
          if (bcnt_r + 5'h01 >= tpb) begin
            bcnt_nxt  = 5'h00;
            btick_nxt = 1'b1;
          end else begin
            bcnt_nxt  = bcnt_r + 5'h01;
          end
          // receiver samples at the bit centre
          bmid_nxt = (bcnt_r == (tpb >> 1));
        end
      end

      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          bcnt_r  <= 5'h00;
          btick_r <= 1'b0;
          bmid_r  <= 1'b0;
          stick_r <= 1'b0;
        end else begin
          bcnt_r  <= bcnt_nxt;
          btick_r <= btick_nxt;
          bmid_r  <= bmid_nxt;
          stick_r <= tick;
        end
      end

      assign samp_tick[c] = stick_r;
      assign bit_tick[c]  = btick_r;
      assign bit_mid[c]   = bmid_r;
    end
  endgenerate
endmodule

// ===== core/frbg_pkg.sv
// frbg_pkg: constants shared by the rate generator files.
// assumes: one system clock; the divisor registers are loaded through a plain write port.
package frbg_pkg;
  // reset values of the divisor registers
  localparam logic [7:0] DIV_LOW_RESET  = 8'h01;
  localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
  localparam logic [7:0] DIV_FRAC_RESET = 8'h00;
  // register selects on the write/read port
  localparam logic [1:0] SEL_DIV_LOW    = 2'h0;
  localparam logic [1:0] SEL_DIV_HIGH   = 2'h1;
  localparam logic [1:0] SEL_DIV_FRAC   = 2'h2;
  localparam logic [1:0] SEL_HANDSHAKE  = 2'h3;
  // field positions
  localparam int FRAC_LSB     = 0;
  localparam int FRAC_W       = 4;
  localparam int SAMP_LSB     = 4;
  localparam int PRESCALE_BIT = 7;
  // sampling-ratio codes of the fraction register
  localparam logic [1:0] SAMP_16X = 2'h0;
  localparam logic [1:0] SAMP_8X  = 2'h1;
  localparam logic [1:0] SAMP_4X  = 2'h2;
  // sampling ticks per bit
  localparam logic [4:0] TICKS_16X = 5'h10;
  localparam logic [4:0] TICKS_8X  = 5'h08;
  localparam logic [4:0] TICKS_4X  = 5'h04;
  // last prescaler count when enabled; the prescaler divides by four
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  // reset pulse width and its cycle count at 20 MHz
  localparam int RESET_MIN_NS  = 40;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESET_MIN_CYC =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ===== core/frbg_chan_div.sv
// frbg_chan_div: one channel's prescaler and fractional divisor.
// assumes: clk_sys is the oscillator clock; settings come from registers.
module frbg_chan_div #(
  parameter int INT_W = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             prescale_en,
  input  wire logic [INT_W-1:0] div_int,
  input  wire logic [3:0]       div_frac,
  output logic                  samp_tick
);
  logic [1:0]       pre_cnt_r, pre_cnt_nxt;
  logic             pre_tick;
  logic [INT_W-1:0] cnt_r, cnt_nxt;
  logic             stretch_r, stretch_nxt;
  logic [3:0]       phase_r, phase_nxt;
  logic             tick_r, tick_nxt;
  logic [4:0]       acc;

  assign pre_tick = !prescale_en || (pre_cnt_r == frbg_pkg::PRESCALE_LAST);
  assign samp_tick = tick_r;

  always_comb begin
    pre_cnt_nxt = prescale_en ? pre_cnt_r + 2'h1 : 2'h0;
    cnt_nxt     = cnt_r;
    stretch_nxt = stretch_r;
    phase_nxt   = phase_r;
    tick_nxt    = 1'b0;
    acc         = {1'b0, phase_r} + {1'b0, div_frac};
    if (pre_tick) begin
      if (cnt_r > INT_W'(1)) begin
        cnt_nxt = cnt_r - 1'b1;
      end else if (stretch_r) begin
        stretch_nxt = 1'b0;
      end else begin
        tick_nxt    = 1'b1;
        cnt_nxt     = (div_int == '0) ? INT_W'(1) : div_int;
        phase_nxt   = acc[3:0];
        stretch_nxt = acc[4];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt_r <= 2'h0;
      cnt_r     <= INT_W'(1);
      stretch_r <= 1'b0;
      phase_r   <= 4'h0;
      tick_r    <= 1'b0;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
      cnt_r     <= cnt_nxt;
      stretch_r <= stretch_nxt;
      phase_r   <= phase_nxt;
      tick_r    <= tick_nxt;
    end
  end
endmodule

// ===== sim/frbg_props.sv
// frbg_props: port checks on the rate generator
// assumes: bound to frbg_rate_gen, one clock
module frbg_props #(parameter int NUM_CH = 2) (
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic              reg_wr,
  input wire logic [1:0]        reg_sel,
  input wire logic [0:0]        reg_ch,
  input wire logic [7:0]        reg_wdata,
  input wire logic [7:0]        reg_rdata,
  input wire logic [NUM_CH-1:0] bit_tick,
  input wire logic [NUM_CH-1:0] bit_mid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_rd;
    reg_wr ##1 !reg_wr && $stable({reg_sel, reg_ch}) |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_rd: assert property (p_rd) else $error("readback");
  property p_hold;
    !reg_wr ##1 !reg_wr && $stable({reg_sel, reg_ch}) |=> $stable(reg_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_b0; bit_tick[0] |=> !bit_tick[0] [*3]; endproperty
  a_b0: assert property (p_b0) else $error("b0");
  property p_b1; bit_tick[1] |=> !bit_tick[1] [*3]; endproperty
  a_b1: assert property (p_b1) else $error("b1");
  property p_m0; bit_mid[0] |=> !bit_mid[0] [*3]; endproperty
  a_m0: assert property (p_m0) else $error("m0");
  property p_m1; bit_mid[1] |=> !bit_mid[1] [*3]; endproperty
  a_m1: assert property (p_m1) else $error("m1");
  property p_c0; bit_mid[0] |-> !bit_tick[0]; endproperty
  a_c0: assert property (p_c0) else $error("c0");
  property p_c1; bit_mid[1] |-> !bit_tick[1]; endproperty
  a_c1: assert property (p_c1) else $error("c1");
endmodule

// ===== sim/frbg_tick_peer.sv
// frbg_tick_peer: channel side counting sampling ticks over whole bits
// assumes: one-clock tick pulses; clr restarts a measurement
module frbg_tick_peer (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        clr,
  input  wire logic [5:0]  nbits,
  input  wire logic        samp_tick,
  input  wire logic        bit_tick,
  output logic      [31:0] n_clk,
  output logic      [31:0] n_samp,
  output logic             done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] st;
  logic [5:0] nb;
  assign done = st == 2'h3;
  // bits from ticks
  // skip the partial bit and one whole bit so a rate change mid-bit is not measured
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n || clr) begin
      st <= 2'h0;
      nb <= 6'h0;
      n_clk <= 32'h0;
      n_samp <= 32'h0;
    end else if (st == 2'h2) begin
      n_clk <= n_clk + 32'h1;
      n_samp <= n_samp + {31'h0, samp_tick};
      nb <= nb + {5'h0, bit_tick};
      if (bit_tick && nb + 6'h1 == nbits) st <= 2'h3;
    end else if (bit_tick && st != 2'h3) st <= st + 2'h1;
  end
endmodule

// ===== sim/testbench.sv
// testbench: register port and tick-rate checks
// assumes: 20 MHz clock; one tick peer per channel
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys, reset_n, reg_wr, rd_en, clr, armed;
  logic [1:0]  reg_sel, samp_tick, bit_tick, bit_mid, done;
  logic [0:0]  reg_ch;
  logic [5:0]  nbits;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [31:0] n_clk [2], n_samp [2], seed, r;
  logic [31:0] exp_q [$];
  int          n_mismatch, n_tests, ms;
  frbg_rate_gen DUT (.clk_sys(clk_sys), .reset_n(reset_n), .reg_wr(reg_wr), .reg_sel(reg_sel),
    .reg_ch(reg_ch), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .samp_tick(samp_tick),
    .bit_tick(bit_tick), .bit_mid(bit_mid));
  for (genvar c = 0; c < 2; c++) begin : g_peer
    frbg_tick_peer u_peer (.clk_sys(clk_sys), .reset_n(reset_n), .clr(clr), .nbits(nbits),
      .samp_tick(samp_tick[c]), .bit_tick(bit_tick[c]), .n_clk(n_clk[c]),
      .n_samp(n_samp[c]), .done(done[c]));
  end
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic results();
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (rd_en) begin
      #2;
      chk({24'h0, reg_rdata}, exp_q.pop_front());
    end else if (armed && done[ms]) begin
      chk(n_clk[ms], exp_q.pop_front());
      chk(n_samp[ms], exp_q.pop_front());
      armed = 1'b0;
    end
  end
  // a read notes its expected value; the port holds one cycle
  task automatic acc(input logic w, input logic [1:0] s, input logic c, input logic [7:0] d);
    if (!w) exp_q.push_back({24'h0, d});
    reg_wr = w;
    rd_en = !w;
    reg_sel = s;
    reg_ch = c;
    reg_wdata = d;
    @(posedge clk_sys) #1;
  endtask
  task automatic rst();
    reset_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    for (int i = 0; i < 8; i++) acc(1'b0, i[1:0], i[2], i[1:0] == 2'h0 ? 8'h01 : 8'h00);
    rd_en = 1'b0;
    $display("reset values done");
  endtask
  task automatic run(input logic c, input logic [7:0] hs, lo, hi, fs);
    logic [7:0] v [4];
    int n;
    int t;
    v = '{lo, hi, fs, hs};
    n = {hi, lo} == 16'h0 ? 1 : int'({hi, lo});
    t = fs[5:4] == 2'h1 ? 8 : fs[5:4] == 2'h2 ? 4 : 16;
    for (int i = 0; i < 4; i++) acc(1'b1, i[1:0], c, v[i]);
    for (int i = 3; i >= 0; i--) acc(1'b0, i[1:0], c, v[i]);
    reg_wr = 1'b0;
    rd_en = 1'b0;
    exp_q.push_back((hs[7] ? 4 : 1) * (32 * n + 2 * fs[3:0]));
    exp_q.push_back(32'h20);
    nbits = 6'(32 / t);
    ms = c;
    clr = 1'b1;
    @(posedge clk_sys) #1;
    clr = 1'b0;
    armed = 1'b1;
    for (int k = 0; k < 20000 && armed; k++) @(posedge clk_sys);
    #1;
    if (armed) begin
      // limit ran out: count it and drop the stale notes
      chk(32'h0, 32'h1);
      armed = 1'b0;
      exp_q.delete();
    end
    $display("rate case ch %0d done", c);
  endtask
  initial begin
    {reg_wr, rd_en, clr, armed, reg_sel, reg_ch, reg_wdata, nbits} = '0;
    {n_tests, n_mismatch, ms} = '0;
    seed = 32'h2d;
    rst();
    run(1'b1, 8'h80, 8'h01, 8'h00, 8'h00);
    run(1'b0, 8'h00, 8'h03, 8'h00, 8'h00);
    run(1'b0, 8'h00, 8'h02, 8'h00, 8'h15);
    run(1'b0, 8'h00, 8'h01, 8'h00, 8'h27);
    run(1'b0, 8'h00, 8'h00, 8'h01, 8'h00);
    repeat (5) begin
      seed = xs(seed);
      r = seed;
      // ratio codes 16X, 4X and the spare code; 8X stays in its fixed case
      // because a 4X to 8X switch may put two bit centres only two ticks apart
      run(r[0], {r[1], 7'h0}, {5'h0, r[4:2]} + 8'h1, 8'h0,
        {2'h0, r[6:5] | {r[5], 1'b0}, r[11:8]});
    end
    rst();
    results();
  end
  initial begin
    #(50 * 60000);
    n_mismatch++;
    results();
  end
endmodule
bind frbg_rate_gen frbg_props #(.NUM_CH(NUM_CH)) u_props (.clk_sys(clk_sys),
  .reset_n(reset_n), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_ch(reg_ch),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bit_tick(bit_tick), .bit_mid(bit_mid));
